// ==== bench/svp_sink.sv ====
// downstream scan-conversion model that takes objects promptly or after a stall
`timescale 1ns/1ps
module svp_sink (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic slow,
  input  wire logic out_valid,
  output logic      out_ready
);
  logic [1:0] age;
  // one ready pulse per object; slow mode waits so the stage must hold its outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age       <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      age       <= out_valid ? age + 2'h1 : 2'h0;
      out_ready <= out_valid && !out_ready && (!slow || age >= 2'h2);
    end
  end
endmodule

// ==== bench/svp_vertex_stage_tb.sv ====
// self-checking bench for the setup-stage vertex position block
`timescale 1ns/1ps
module svp_vertex_stage_tb;
  import svp_pkg::*;
  logic              CLK_SYS = 1'b0, ARST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [9:0]        AVS_ADDRESS = 10'h000;
  logic [31:0]       AVS_WRITEDATA = 32'h0, AVS_READDATA, IN_PT_WIDTH = 32'h0, q;
  logic              AVS_WAITREQUEST, IN_VALID = 1'b0, IN_READY, OUT_VALID, OUT_READY;
  logic [1:0]        IN_TYPE = 2'h0, OUT_TYPE, ctype;
  logic [3:0]        IN_VP_INDEX = 4'h0;
  logic [2:0][31:0]  IN_X = '0, IN_Y = '0, IN_Z = '0, IN_RW = '0;
  logic [2:0]        OUT_VTX_COUNT, ccount;
  logic              OUT_EDGE_RULE, crule, slow = 1'b0, ce = 1'b1;
  logic [3:0][23:0]  OUT_X, OUT_Y, cx, cy;
  logic [3:0][31:0]  OUT_Z, OUT_RW, cz, crw;
  int                num_errors = 0, tests_run = 0, cyc = 0, n_out = 0, n0;
  logic [31:0]       m [6] = '{32'h00020000, 32'h00010000, 32'h00010000, 32'h0,
                               32'h00010000, 32'h0};
  // ==========================================================
  // design, far-side model, clock and capture
  svp_vertex_stage uut (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CE(ce),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
    .IN_TYPE(IN_TYPE), .IN_VP_INDEX(IN_VP_INDEX), .IN_X(IN_X), .IN_Y(IN_Y), .IN_Z(IN_Z),
    .IN_RW(IN_RW), .IN_PT_WIDTH(IN_PT_WIDTH), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
    .OUT_TYPE(OUT_TYPE), .OUT_VTX_COUNT(OUT_VTX_COUNT), .OUT_EDGE_RULE(OUT_EDGE_RULE),
    .OUT_X(OUT_X), .OUT_Y(OUT_Y), .OUT_Z(OUT_Z), .OUT_RW(OUT_RW));
  svp_sink sink (.clk(CLK_SYS), .arst_n(ARST_N), .slow(slow), .out_valid(OUT_VALID),
    .out_ready(OUT_READY));
  always #50 CLK_SYS = ~CLK_SYS;
  // outputs are taken only at the handshake edge, as the scan-conversion side would
  always @(posedge CLK_SYS) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      results();
    end else if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
      {cx, cy, cz, crw, ctype, ccount, crule} <= {OUT_X, OUT_Y, OUT_Z, OUT_RW, OUT_TYPE,
                                                  OUT_VTX_COUNT, OUT_EDGE_RULE};
      n_out <= n_out + 1;
    end
  end
  // ==========================================================
  // shared tasks
  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // avalon access held until the edge that samples waitrequest low
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    {AVS_WRITE, AVS_READ, AVS_ADDRESS, AVS_WRITEDATA} <= {w, !w, a, d};
    do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    {AVS_WRITE, AVS_READ} <= 2'b00;
  endtask
  task send(input logic [1:0] t);
    n0 = n_out;
    @(posedge CLK_SYS);
    {IN_VALID, IN_TYPE} <= {1'b1, t};
    do @(posedge CLK_SYS); while (IN_READY !== 1'b1);
    IN_VALID <= 1'b0;
    repeat (12) @(posedge CLK_SYS);
  endtask
  task results();
    $display("tests %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task t_point();
    bus(1'b1, 10'h000, 32'h00000022);
    bus(1'b0, 10'h000, 32'h0);
    chk(q, 32'h00000022);
    bus(1'b1, 10'h004, 32'h00020000);
    bus(1'b0, 10'h01c, 32'h0);
    chk(q, 32'h0);
    {IN_X[0], IN_Y[0], IN_Z[0], IN_RW[0], slow} <= {32'h41200000, 32'h41a00000,
                                                    32'h3f800000, 32'h40000000, 1'b1};
    send(2'h0);
    chk(n_out - n0, 32'h1);
    chk({ccount, crule}, {3'h4, 1'b1});
    chk({cx[0], cy[0]}, {24'h000b00, 24'h001500});
    chk({cx[1], cy[3]}, {24'h000900, 24'h001300});
    chk(cz[3], 32'h00010000);
    chk(crw[2], 32'h40000000);
    // width from the vertex this time, with the vertical half-pixel bias on
    bus(1'b1, 10'h000, 32'h00000016);
    IN_PT_WIDTH <= 32'h40800000;
    send(2'h0);
    chk({cx[2], cy[2]}, {24'h000800, 24'h001180});
    chk({ctype, ccount, crule}, {2'h0, 3'h4, 1'b0});
    $display("point test done");
  endtask
  task t_nan_then_rect();
    {IN_X[0], slow} <= {32'h7fc00000, 1'b0};
    send(2'h0);
    chk(n_out - n0, 32'h0);
    // a frozen stage must not take the waiting nan object
    {ce, IN_VALID} <= 2'b01;
    repeat (3) @(posedge CLK_SYS);
    {ce, IN_VALID} <= 2'b10;
    bus(1'b0, 10'h010, 32'h0);
    chk(q, 32'h1);
    for (int k = 0; k < 6; k++) bus(1'b1, 10'h220 + 10'(k * 4), m[k]);
    bus(1'b1, 10'h000, 32'h00000003);
    bus(1'b1, 10'h008, 32'h00000003);
    {IN_VP_INDEX, IN_Z} <= {4'h1, 96'h0};
    IN_X <= {32'h0, 32'h0, 32'h40800000};
    IN_Y <= {32'h0, 32'h40800000, 32'h40800000};
    send(2'h3);
    chk(n_out - n0, 32'h1);
    chk({cx[0], cx[1]}, {24'h000c00, 24'h000400});
    chk({cx[3], cy[3]}, {24'h000c00, 24'h0});
    chk({ctype, ccount}, {2'h3, 3'h4});
    // infinity times a zero scale of entry 0 turns into a nan after transform
    {IN_VP_INDEX, IN_X[0]} <= {4'h0, 32'h7f800000};
    send(2'h0);
    chk(n_out - n0, 32'h0);
    bus(1'b0, 10'h010, 32'h0);
    chk(q, 32'h2);
    $display("cull and rectangle test done");
  endtask
  task t_clamp_round();
    bus(1'b1, 10'h000, 32'h00000008);
    // origin far right so a short line still crosses the guardband edge
    bus(1'b1, 10'h008, 32'h00007ff0);
    IN_X <= {32'h0, 32'h3f180000, 32'h42000000};
    IN_Y <= '0;
    send(2'h1);
    chk({cx[0], cy[0]}, {24'h7fff00, 24'h0});
    chk(cx[1], 24'h7ff020);
    $display("clamp and rounding test done");
  endtask
  initial begin
    repeat (12) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    t_point();
    t_nan_then_rect();
    t_clamp_round();
    results();
  end
endmodule

// ==== src/svp_params.svh ====
// constants for the setup-stage vertex position block
`ifndef SVP_PARAMS_SVH
`define SVP_PARAMS_SVH

// register byte offsets
`define SVP_REG_CTRL        10'h000
`define SVP_REG_POINT_WIDTH 10'h004
`define SVP_REG_ORIGIN      10'h008
`define SVP_REG_STATUS      10'h00c
`define SVP_REG_CULL_COUNT  10'h010
`define SVP_REG_OBJ_COUNT   10'h014
// viewport table: address bit 9 set, entry in bits 8:5, coefficient in bits 4:2
`define SVP_VP_SEL_BIT      9
`define SVP_VP_COEFS        6

// control register fields
`define SVP_CTRL_VP_EN      0
`define SVP_CTRL_SUB8       1
`define SVP_CTRL_PW_VERTEX  2
`define SVP_CTRL_HBIAS      3
`define SVP_CTRL_VBIAS      4
`define SVP_CTRL_PT_RULE    5
`define SVP_CTRL_WIDTH      6

// viewport coefficient slots
`define SVP_M00 0
`define SVP_M30 1
`define SVP_M11 2
`define SVP_M31 3
`define SVP_M22 4
`define SVP_M32 5

// number formats: positions are Q24.16 inside, floats are single precision
`define SVP_FRAC            16
`define SVP_FLT_Q_EXP       8'd134
`define SVP_FLT_SAT_EXP     8'd149
`define SVP_FLT_MANT_BITS   8'd24
`define SVP_HALF_PIXEL      40'sh0000008000
`define SVP_POS_MAX         40'sh7fffffffff
`define SVP_POS_MIN         40'sh8000000000
`define SVP_Z_MAX           40'sh007fffffff
`define SVP_Z_MIN           40'shff80000000
`define SVP_GB_MAX          40'sh0000007fff
`define SVP_GB_MIN          40'shffffff8000
`define SVP_OUT_GB_MAX      24'sh7fff00

`endif

// ==== src/svp_pkg.sv ====
// types shared by the setup-stage vertex position block
package svp_pkg;

  // processing sequence, one-hot
  typedef enum logic [4:0] {
    SVP_S_IDLE   = 5'b00001,
    SVP_S_XFORM  = 5'b00010,
    SVP_S_EXPAND = 5'b00100,
    SVP_S_QUANT  = 5'b01000,
    SVP_S_OUT    = 5'b10000
  } svp_state_t;

  // basic object kinds delivered by primitive decomposition
  typedef enum logic [1:0] {
    SVP_OBJ_POINT = 2'h0,
    SVP_OBJ_LINE  = 2'h1,
    SVP_OBJ_TRI   = 2'h2,
    SVP_OBJ_RECT  = 2'h3
  } svp_obj_t;

endpackage

// ==== src/svp_vertex_stage.sv ====
// setup-stage vertex position processing with avalon register slave
`timescale 1ns/1ps
`include "svp_params.svh"

module svp_vertex_stage
  import svp_pkg::*;
#(
  parameter int VP_COUNT = 16
) (
  input  wire logic                   CLK_SYS,
  input  wire logic                   ARST_N,
  input  wire logic                   CE,
  // avalon-mm register slave
  input  wire logic [9:0]             AVS_ADDRESS,
  input  wire logic                   AVS_READ,
  input  wire logic                   AVS_WRITE,
  input  wire logic [31:0]            AVS_WRITEDATA,
  input  wire logic [3:0]             AVS_BYTEENABLE,
  output logic      [31:0]            AVS_READDATA,
  output logic                        AVS_WAITREQUEST,
  // object input from primitive decomposition
  input  wire logic                   IN_VALID,
  output logic                        IN_READY,
  input  wire logic [1:0]             IN_TYPE,
  input  wire logic [3:0]             IN_VP_INDEX,
  input  wire logic [2:0][31:0]       IN_X,
  input  wire logic [2:0][31:0]       IN_Y,
  input  wire logic [2:0][31:0]       IN_Z,
  input  wire logic [2:0][31:0]       IN_RW,
  input  wire logic [31:0]            IN_PT_WIDTH,
  // object output to scan-conversion setup
  output logic                        OUT_VALID,
  input  wire logic                   OUT_READY,
  output logic [1:0]                  OUT_TYPE,
  output logic [2:0]                  OUT_VTX_COUNT,
  output logic                        OUT_EDGE_RULE,
  output logic [3:0][23:0]            OUT_X,
  output logic [3:0][23:0]            OUT_Y,
  output logic [3:0][31:0]            OUT_Z,
  output logic [3:0][31:0]            OUT_RW
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    svp_state_t                          st;
    logic [`SVP_CTRL_WIDTH-1:0]          ctrl;
    logic [31:0]                         pt_width;
    logic [15:0]                         org_x;
    logic [15:0]                         org_y;
    logic [VP_COUNT-1:0][5:0][31:0]      vp;
    logic [15:0]                         cull_cnt;
    logic [15:0]                         obj_cnt;
    logic                                ack;
    logic [31:0]                         rdata;
    logic                                in_ready;
    logic [1:0]                          typ;
    logic [3:0]                          vp_idx;
    logic [2:0][2:0]                     inf;
    logic [3:0][39:0]                    px;
    logic [3:0][39:0]                    py;
    logic [3:0][39:0]                    pz;
    logic [3:0][31:0]                    prw;
    logic [39:0]                         pwidth;
    logic                                out_valid;
    logic [1:0]                          out_type;
    logic [2:0]                          out_cnt;
    logic                                out_rule;
    logic [3:0][23:0]                    out_x;
    logic [3:0][23:0]                    out_y;
    logic [3:0][31:0]                    out_z;
    logic [3:0][31:0]                    out_rw;
  } svp_regs_t;

  svp_regs_t r;
  svp_regs_t n;
  logic      acc;
  logic      in_nan;
  logic      vp_nan;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  // ==========================================================================
  // arithmetic helpers
  // ==========================================================================
  // single float to Q24.16; infinities saturate, denormals flush to zero
  function automatic logic signed [39:0] f2q(input logic [31:0] f);
    logic [7:0]  e;
    logic [39:0] mant;
    logic [39:0] mag;
    e    = f[30:23];
    mant = {16'h0000, 1'b1, f[22:0]};
    if (e == 8'h00)
      mag = 40'h0;
    else if (e > `SVP_FLT_SAT_EXP)
      mag = `SVP_POS_MAX;
    else if (e >= `SVP_FLT_Q_EXP)
      mag = mant << (e - `SVP_FLT_Q_EXP);
    else if ((`SVP_FLT_Q_EXP - e) < `SVP_FLT_MANT_BITS)
      mag = mant >> (`SVP_FLT_Q_EXP - e);
    else
      mag = 40'h0;
    f2q = f[31] ? -$signed(mag) : $signed(mag);
  endfunction

  function automatic logic is_nan(input logic [31:0] f);
    is_nan = (&f[30:23]) & (|f[22:0]);
  endfunction

  function automatic logic is_inf(input logic [31:0] f);
    is_inf = (&f[30:23]) & ~(|f[22:0]);
  endfunction

  // scale and translate in fixed point, saturating at the internal range
  function automatic logic signed [39:0] mac(input logic signed [39:0] x,
                                             input logic [31:0] m,
                                             input logic [31:0] t);
    logic signed [71:0] prod;
    logic signed [71:0] sum;
    prod = x * $signed({{40{m[31]}}, m});
    sum  = (prod >>> `SVP_FRAC) + $signed({{40{t[31]}}, t});
    if (sum > $signed({{32{1'b0}}, `SVP_POS_MAX}))
      mac = `SVP_POS_MAX;
    else if (sum < $signed({{32{1'b1}}, `SVP_POS_MIN}))
      mac = `SVP_POS_MIN;
    else
      mac = sum[39:0];
  endfunction

  // round to subpixel (ties to even), clamp to the guardband, emit Q16.8
  function automatic logic [23:0] quant(input logic signed [39:0] v, input logic sub8);
    logic signed [39:0] q;
    logic [11:0]        rem;
    logic [11:0]        half;
    logic signed [39:0] hi;
    logic signed [39:0] lo;
    if (sub8) begin
      q    = v >>> 8;
      rem  = {4'h0, v[7:0]};
      half = 12'h080;
      hi   = `SVP_GB_MAX <<< 8;
      lo   = `SVP_GB_MIN <<< 8;
    end else begin
      q    = v >>> 12;
      rem  = v[11:0];
      half = 12'h800;
      hi   = `SVP_GB_MAX <<< 4;
      lo   = `SVP_GB_MIN <<< 4;
    end
    if ((rem > half) || ((rem == half) && q[0]))
      q = q + 40'sh1;
    if (q > hi)
      q = hi;
    else if (q < lo)
      q = lo;
    quant = sub8 ? q[23:0] : {q[19:0], 4'h0};
  endfunction

  function automatic logic [31:0] zsat(input logic signed [39:0] z);
    if (z > `SVP_Z_MAX)
      zsat = 32'h7fffffff;
    else if (z < `SVP_Z_MIN)
      zsat = 32'h80000000;
    else
      zsat = z[31:0];
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      be_merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  function automatic logic [2:0] vtx_count(input logic [1:0] t);
    vtx_count = (t == SVP_OBJ_POINT) ? 3'd1 : (t == SVP_OBJ_LINE) ? 3'd2 : 3'd3;
  endfunction

  // ==========================================================================
  // next-state logic
  // ==========================================================================
  always_comb begin
    logic signed [39:0] ox;
    logic signed [39:0] oy;
    logic signed [39:0] hw;
    logic signed [39:0] bx;
    logic signed [39:0] by;
    logic [5:0][31:0]   m;
    n  = r;
    ox = '0;
    oy = '0;
    hw = '0;
    bx = '0;
    by = '0;
    m  = r.vp[r.vp_idx];
    acc    = IN_VALID & r.in_ready;
    in_nan = 1'b0;
    vp_nan = 1'b0;
    // only the vertices the object really has are examined
    for (int v = 0; v < 3; v++) begin
      if (3'(v) < vtx_count(IN_TYPE))
        in_nan = in_nan | is_nan(IN_X[v]) | is_nan(IN_Y[v])
                        | is_nan(IN_Z[v]) | is_nan(IN_RW[v]);
    end

    // register slave: one wait cycle, then one acknowledge cycle
    n.ack   = (AVS_READ | AVS_WRITE) & ~r.ack;
    n.rdata = 32'h0;
    if (AVS_READ & ~r.ack) begin
      if (AVS_ADDRESS[`SVP_VP_SEL_BIT]) begin
        if (AVS_ADDRESS[4:2] < 3'(`SVP_VP_COEFS))
          n.rdata = r.vp[AVS_ADDRESS[8:5]][AVS_ADDRESS[4:2]];
      end else begin
        unique case (AVS_ADDRESS)
          `SVP_REG_CTRL:        n.rdata = {26'h0, r.ctrl};
          `SVP_REG_POINT_WIDTH: n.rdata = r.pt_width;
          `SVP_REG_ORIGIN:      n.rdata = {r.org_y, r.org_x};
          `SVP_REG_STATUS:      n.rdata = {26'h0, r.st, r.out_valid} & 32'h3f;
          `SVP_REG_CULL_COUNT:  n.rdata = {16'h0, r.cull_cnt};
          `SVP_REG_OBJ_COUNT:   n.rdata = {16'h0, r.obj_cnt};
          default:              n.rdata = 32'h0;
        endcase
      end
    end
    // writes take effect on the acknowledge cycle; unmapped writes vanish
    if (AVS_WRITE & r.ack) begin
      if (AVS_ADDRESS[`SVP_VP_SEL_BIT]) begin
        if (AVS_ADDRESS[4:2] < 3'(`SVP_VP_COEFS))
          n.vp[AVS_ADDRESS[8:5]][AVS_ADDRESS[4:2]] =
            be_merge(r.vp[AVS_ADDRESS[8:5]][AVS_ADDRESS[4:2]], AVS_WRITEDATA, AVS_BYTEENABLE);
      end else begin
        unique case (AVS_ADDRESS)
          `SVP_REG_CTRL: n.ctrl = 6'(be_merge({26'h0, r.ctrl}, AVS_WRITEDATA, AVS_BYTEENABLE));
          `SVP_REG_POINT_WIDTH: n.pt_width = be_merge(r.pt_width, AVS_WRITEDATA, AVS_BYTEENABLE);
          // any origin is taken, even far off screen
          `SVP_REG_ORIGIN: {n.org_y, n.org_x} =
            be_merge({r.org_y, r.org_x}, AVS_WRITEDATA, AVS_BYTEENABLE);
          default: ;
        endcase
      end
    end

    // object sequence: each step in its own cycle keeps the order fixed
    unique case (r.st)
      SVP_S_IDLE: begin
        if (acc) begin
          if (in_nan) begin
            // only this object is lost; the stage stays ready for the next
            n.cull_cnt = r.cull_cnt + 16'h1;
          end else begin
            n.in_ready = 1'b0;
            n.st       = SVP_S_XFORM;
            n.typ      = IN_TYPE;
            n.vp_idx   = IN_VP_INDEX;
            for (int v = 0; v < 3; v++) begin
              n.px[v]  = f2q(IN_X[v]);
              n.py[v]  = f2q(IN_Y[v]);
              n.pz[v]  = f2q(IN_Z[v]);
              n.prw[v] = IN_RW[v];
              n.inf[v] = (3'(v) < vtx_count(IN_TYPE)) ?
                         {is_inf(IN_Z[v]), is_inf(IN_Y[v]), is_inf(IN_X[v])} : 3'h0;
            end
            n.px[3]  = '0;
            n.py[3]  = '0;
            n.pz[3]  = '0;
            n.prw[3] = '0;
            n.pwidth = r.ctrl[`SVP_CTRL_PW_VERTEX] ? f2q(IN_PT_WIDTH)
                                                   : {{8{r.pt_width[31]}}, r.pt_width};
          end
        end
      end
      SVP_S_XFORM: begin
        n.st = SVP_S_EXPAND;
        if (r.ctrl[`SVP_CTRL_VP_EN]) begin
          for (int v = 0; v < 3; v++) begin
            // an infinity scaled by zero is the only way to make a NaN here
            vp_nan = vp_nan | (r.inf[v][0] & (m[`SVP_M00] == 32'h0))
                            | (r.inf[v][1] & (m[`SVP_M11] == 32'h0))
                            | (r.inf[v][2] & (m[`SVP_M22] == 32'h0));
            n.px[v] = mac(r.px[v], m[`SVP_M00], m[`SVP_M30]);
            n.py[v] = mac(r.py[v], m[`SVP_M11], m[`SVP_M31]);
            n.pz[v] = mac(r.pz[v], m[`SVP_M22], m[`SVP_M32]);
          end
          if (vp_nan) begin
            n.st       = SVP_S_IDLE;
            n.in_ready = 1'b1;
            n.cull_cnt = r.cull_cnt + 16'h1;
          end
        end
      end
      SVP_S_EXPAND: begin
        n.st = SVP_S_QUANT;
        ox   = {{8{r.org_x[15]}}, r.org_x, 16'h0};
        oy   = {{8{r.org_y[15]}}, r.org_y, 16'h0};
        hw   = $signed(r.pwidth) >>> 1;
        for (int v = 0; v < 3; v++) begin
          n.px[v] = r.px[v] + ox;
          n.py[v] = r.py[v] + oy;
        end
        if (r.typ == SVP_OBJ_POINT) begin
          // corners: lower right, lower left, upper left, upper right
          n.px[0] = r.px[0] + ox + hw;
          n.py[0] = r.py[0] + oy + hw;
          n.px[1] = r.px[0] + ox - hw;
          n.py[1] = r.py[0] + oy + hw;
          n.px[2] = r.px[0] + ox - hw;
          n.py[2] = r.py[0] + oy - hw;
          n.px[3] = r.px[0] + ox + hw;
          n.py[3] = r.py[0] + oy - hw;
          for (int v = 1; v < 4; v++) begin
            n.pz[v]  = r.pz[0];
            n.prw[v] = r.prw[0];
          end
        end else if (r.typ == SVP_OBJ_RECT) begin
          // opposite corner of the lower-left vertex; origin added once to the pre-origin sum
          n.px[3]  = r.px[0] + r.px[2] - r.px[1] + ox;
          n.py[3]  = r.py[0] + r.py[2] - r.py[1] + oy;
          n.pz[3]  = '0;
          n.prw[3] = '0;
        end
      end
      SVP_S_QUANT: begin
        n.st        = SVP_S_OUT;
        n.out_valid = 1'b1;
        n.out_type  = r.typ;
        n.out_cnt   = (r.typ == SVP_OBJ_POINT || r.typ == SVP_OBJ_RECT) ? 3'd4
                                                                          : vtx_count(r.typ);
        n.out_rule  = r.ctrl[`SVP_CTRL_PT_RULE] & (r.typ == SVP_OBJ_POINT);
        // moving the grid by half a pixel lets the rasterizer sample integers
        bx = r.ctrl[`SVP_CTRL_HBIAS] ? `SVP_HALF_PIXEL : 40'sh0;
        by = r.ctrl[`SVP_CTRL_VBIAS] ? `SVP_HALF_PIXEL : 40'sh0;
        for (int v = 0; v < 4; v++) begin
          n.out_x[v]  = quant(r.px[v] - bx, r.ctrl[`SVP_CTRL_SUB8]);
          n.out_y[v]  = quant(r.py[v] - by, r.ctrl[`SVP_CTRL_SUB8]);
          n.out_z[v]  = zsat(r.pz[v]);
          n.out_rw[v] = r.prw[v];
        end
      end
      SVP_S_OUT: begin
        if (OUT_READY) begin
          n.out_valid = 1'b0;
          n.in_ready  = 1'b1;
          n.st        = SVP_S_IDLE;
          n.obj_cnt   = r.obj_cnt + 16'h1;
        end
      end
    endcase
  end

  // ==========================================================================
  // state register; low clock enable freezes everything
  // ==========================================================================
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      r          <= '0;
      r.st       <= SVP_S_IDLE;
      r.in_ready <= 1'b1;
    end else if (CE) begin
      r <= n;
    end
  end

  assign AVS_READDATA    = r.rdata;
  assign AVS_WAITREQUEST = ~r.ack;
  assign IN_READY        = r.in_ready;
  assign OUT_VALID       = r.out_valid;
  assign OUT_TYPE        = r.out_type;
  assign OUT_VTX_COUNT   = r.out_cnt;
  assign OUT_EDGE_RULE   = r.out_rule;
  assign OUT_X           = r.out_x;
  assign OUT_Y           = r.out_y;
  assign OUT_Z           = r.out_z;
  assign OUT_RW          = r.out_rw;

  // ==========================================================================
  // assertions
  // ==========================================================================
  sequence s_clean_accept;
    CE && acc && !in_nan && !r.ctrl[`SVP_CTRL_VP_EN];
  endsequence

  sequence s_run_three;
    CE [*3];
  endsequence

  property p_nan_cull;
    CE && acc && in_nan |=> (r.cull_cnt == $past(r.cull_cnt) + 16'h1) && IN_READY;
  endproperty
  a_nan_cull: assert property (p_nan_cull) else $error("nan object not culled");

  property p_xform_nan;
    CE && r.st == SVP_S_XFORM && vp_nan |=> r.st == SVP_S_IDLE && !OUT_VALID;
  endproperty
  a_xform_nan: assert property (p_xform_nan) else $error("post-transform nan kept");

  property p_latency;
    s_clean_accept ##1 s_run_three |=> OUT_VALID;
  endproperty
  a_latency: assert property (p_latency) else $error("object not out after four steps");

  property p_guardband;
    OUT_VALID |-> $signed(OUT_X[0]) <= `SVP_OUT_GB_MAX && $signed(OUT_Y[3]) <= `SVP_OUT_GB_MAX;
  endproperty
  a_guardband: assert property (p_guardband) else $error("vertex beyond guardband");

  property p_sub4;
    OUT_VALID && !r.ctrl[`SVP_CTRL_SUB8] && $rose(OUT_VALID) |-> OUT_X[0][3:0] == 4'h0
                                                            && OUT_Y[1][3:0] == 4'h0;
  endproperty
  a_sub4: assert property (p_sub4) else $error("4-bit precision has low bits set");

  property p_point_attr;
    OUT_VALID && OUT_TYPE == SVP_OBJ_POINT |-> OUT_Z[3] == OUT_Z[0] && OUT_RW[2] == OUT_RW[0]
                                            && OUT_VTX_COUNT == 3'd4;
  endproperty
  a_point_attr: assert property (p_point_attr) else $error("point corner attrs differ");

  property p_point_square;
    OUT_VALID && OUT_TYPE == SVP_OBJ_POINT |-> OUT_X[0] == OUT_X[3] && OUT_X[1] == OUT_X[2]
                                            && OUT_Y[0] == OUT_Y[1] && OUT_Y[2] == OUT_Y[3];
  endproperty
  a_point_square: assert property (p_point_square) else $error("point is not a square");

  property p_out_hold;
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_X) && !IN_READY;
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output dropped while stalled");

  property p_bus_ack;
    CE && (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("slave did not answer");

endmodule
